// >>> design/prop_tlv_decoder.v
// Byte-serial decoder for the proprietary information object
`timescale 1ns/10ps
`default_nettype none
`include "prop_tlv_regs.vh"
module prop_tlv_decoder #(
  parameter MEM_WIDTH = 32
) (
  input wire I_CLOCK,
  input wire I_RSTN,
  input wire I_START,
  input wire [1:0] I_FILE_KIND,
  input wire I_BYTE_VALID,
  input wire [7:0] I_BYTE,
  output wire O_BUSY,
  output reg O_DONE,
  output reg O_ERROR,
  output reg O_ERR_ORDER,
  output reg O_ERR_PERMISSION,
  output reg O_ERR_RESERVED,
  output reg O_CHR_VALID,
  output reg O_STOP_ALLOWED,
  output reg O_STOP_HIGH,
  output reg O_STOP_LOW,
  output reg O_STOP_LEVEL_RFU,
  output reg O_CLASS_A,
  output reg O_CLASS_B,
  output reg O_CLASS_C,
  output reg O_POWER_VALID,
  output reg [3:0] O_POWER_INDEX,
  output reg [7:0] O_POWER_CLASS,
  output reg [5:0] O_POWER_MA,
  output reg O_POWER_MA_USABLE,
  output reg [7:0] O_POWER_FREQ,
  output reg O_POWER_FREQ_GIVEN,
  output reg O_MINCLK_VALID,
  output reg [3:0] O_MINCLK_INDEX,
  output reg [7:0] O_MINCLK_FREQ,
  output reg O_MINCLK_GIVEN,
  output reg O_MEM_VALID,
  output reg [MEM_WIDTH-1:0] O_MEM_BYTES
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_OUTER_LEN = 7'h02;
  localparam [6:0] S_TAG = 7'h04;
  localparam [6:0] S_LEN = 7'h08;
  localparam [6:0] S_VALUE = 7'h10;
  localparam [6:0] S_SKIP = 7'h20;
  localparam [6:0] S_FAIL = 7'h40;

  reg [6:0] state_reg;
  reg [7:0] outer_left_reg;
  reg [7:0] inner_left_reg;
  reg [7:0] tag_reg;
  reg [7:0] byte_pos_reg;
  reg [7:0] last_tag_reg;
  reg [3:0] seen_reg;
  reg [3:0] power_count_reg;
  reg [3:0] minclk_count_reg;
  reg [7:0] power_class_reg;
  reg [7:0] power_cons_reg;
  reg [MEM_WIDTH-1:0] mem_acc_reg;

  wire len_error;
  wire not_permitted;
  wire tag_known;
  wire take = I_BYTE_VALID && (state_reg != S_IDLE) && (state_reg != S_FAIL);
  // Container bytes still free once the length byte itself is taken
  wire [7:0] len_room = outer_left_reg - 8'h01;

  tlv_field_check u_check (
    .i_tag(tag_reg),
    .i_len(I_BYTE),
    .i_remaining(len_room),
    .i_file_kind(I_FILE_KIND),
    .o_len_error(len_error),
    .o_not_permitted(not_permitted),
    .o_known(tag_known)
  );

  function [1:0] tag_slot;
    input [7:0] tag;
    begin
      tag_slot = tag[1:0];
    end
  endfunction

  function is_nested_tag;
    input [7:0] tag;
    begin
      is_nested_tag = (tag >= `TAG_CHARACTERISTICS) && (tag <= `TAG_MEMORY);
    end
  endfunction

  assign O_BUSY = (state_reg != S_IDLE);

  always @(posedge I_CLOCK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      state_reg <= S_IDLE;
      outer_left_reg <= 8'h00;
      inner_left_reg <= 8'h00;
      tag_reg <= 8'h00;
      byte_pos_reg <= 8'h00;
      last_tag_reg <= 8'h00;
      seen_reg <= 4'h0;
      power_count_reg <= 4'h0;
      minclk_count_reg <= 4'h0;
      power_class_reg <= 8'h00;
      power_cons_reg <= 8'h00;
      mem_acc_reg <= {MEM_WIDTH{1'b0}};
      O_DONE <= 1'b0;
      O_ERROR <= 1'b0;
      O_ERR_ORDER <= 1'b0;
      O_ERR_PERMISSION <= 1'b0;
      O_ERR_RESERVED <= 1'b0;
      O_CHR_VALID <= 1'b0;
      O_STOP_ALLOWED <= 1'b0;
      O_STOP_HIGH <= 1'b0;
      O_STOP_LOW <= 1'b0;
      O_STOP_LEVEL_RFU <= 1'b0;
      O_CLASS_A <= 1'b0;
      O_CLASS_B <= 1'b0;
      O_CLASS_C <= 1'b0;
      O_POWER_VALID <= 1'b0;
      O_POWER_INDEX <= 4'h0;
      O_POWER_CLASS <= 8'h00;
      O_POWER_MA <= 6'h00;
      O_POWER_MA_USABLE <= 1'b0;
      O_POWER_FREQ <= 8'h00;
      O_POWER_FREQ_GIVEN <= 1'b0;
      O_MINCLK_VALID <= 1'b0;
      O_MINCLK_INDEX <= 4'h0;
      O_MINCLK_FREQ <= 8'h00;
      O_MINCLK_GIVEN <= 1'b0;
      O_MEM_VALID <= 1'b0;
      O_MEM_BYTES <= {MEM_WIDTH{1'b0}};
    end
    else
    begin
      O_DONE <= 1'b0;
      O_POWER_VALID <= 1'b0;
      O_MINCLK_VALID <= 1'b0;
      O_MEM_VALID <= 1'b0;
      if (I_START)
      begin
        state_reg <= S_TAG;
        outer_left_reg <= 8'h00;
        last_tag_reg <= 8'h00;
        seen_reg <= 4'h0;
        power_count_reg <= 4'h0;
        minclk_count_reg <= 4'h0;
        O_ERROR <= 1'b0;
        O_ERR_ORDER <= 1'b0;
        O_ERR_PERMISSION <= 1'b0;
        O_ERR_RESERVED <= 1'b0;
        O_CHR_VALID <= 1'b0;
        // Outer tag is expected first; S_TAG with byte_pos_reg at 8'hFF means outer
        tag_reg <= 8'h00;
        byte_pos_reg <= 8'hFF;
      end
      else if (take)
      begin
        if (state_reg != S_TAG || byte_pos_reg != 8'hFF)
          outer_left_reg <= outer_left_reg - 8'h01;
        case (state_reg)
          S_TAG:
          begin
            if (byte_pos_reg == 8'hFF)
            begin
              if (I_BYTE == `TAG_PROPRIETARY)
                state_reg <= S_OUTER_LEN;
              else
              begin
                O_ERROR <= 1'b1;
                state_reg <= S_FAIL;
              end
            end
            else if (outer_left_reg == 8'h01)
            begin
              // Tag is the container's last byte: no room for its length
              O_ERROR <= 1'b1;
              state_reg <= S_FAIL;
            end
            else
            begin
              tag_reg <= I_BYTE;
              // Same tag already seen but not directly before breaks grouping
              if (is_nested_tag(I_BYTE) && seen_reg[tag_slot(I_BYTE)]
                && I_BYTE != last_tag_reg)
                O_ERR_ORDER <= 1'b1;
              if (is_nested_tag(I_BYTE))
                seen_reg[tag_slot(I_BYTE)] <= 1'b1;
              last_tag_reg <= I_BYTE;
              state_reg <= S_LEN;
            end
          end
          S_OUTER_LEN:
          begin
            outer_left_reg <= I_BYTE;
            byte_pos_reg <= 8'h00;
            state_reg <= (I_BYTE == 8'h00) ? S_IDLE : S_TAG;
            if (I_BYTE == 8'h00)
            begin
              O_DONE <= 1'b1;
              if (I_FILE_KIND == `FILE_ROOT)
                O_ERR_PERMISSION <= 1'b1;
            end
          end
          S_LEN:
          begin
            inner_left_reg <= I_BYTE;
            byte_pos_reg <= 8'h00;
            mem_acc_reg <= {MEM_WIDTH{1'b0}};
            if (tag_known && not_permitted)
              O_ERR_PERMISSION <= 1'b1;
            if (len_error)
            begin
              O_ERROR <= 1'b1;
              state_reg <= S_FAIL;
            end
            else if (I_BYTE == 8'h00)
              state_reg <= (outer_left_reg == 8'h01) ? S_IDLE : S_TAG;
            else
              state_reg <= tag_known ? S_VALUE : S_SKIP;
            if (!len_error && I_BYTE == 8'h00 && outer_left_reg == 8'h01)
            begin
              O_DONE <= 1'b1;
              if (I_FILE_KIND == `FILE_ROOT && !seen_reg[0])
                O_ERR_PERMISSION <= 1'b1;
            end
          end
          S_VALUE, S_SKIP:
          begin
            inner_left_reg <= inner_left_reg - 8'h01;
            byte_pos_reg <= byte_pos_reg + 8'h01;
            if (state_reg == S_VALUE)
            begin
              case (tag_reg)
                `TAG_CHARACTERISTICS:
                begin
                  O_CHR_VALID <= 1'b1;
                  O_STOP_ALLOWED <= I_BYTE[`CHR_STOP_ALLOWED];
                  O_STOP_HIGH <= I_BYTE[`CHR_HIGH_PREF];
                  O_STOP_LOW <= I_BYTE[`CHR_LOW_PREF];
                  O_STOP_LEVEL_RFU <= I_BYTE[`CHR_HIGH_PREF] & I_BYTE[`CHR_LOW_PREF];
                  O_CLASS_A <= I_BYTE[`CHR_CLASS_A];
                  O_CLASS_B <= I_BYTE[`CHR_CLASS_B];
                  O_CLASS_C <= I_BYTE[`CHR_CLASS_C];
                  if (I_BYTE[`CHR_RESERVED_LO] | I_BYTE[`CHR_RESERVED_HI])
                    O_ERR_RESERVED <= 1'b1;
                end
                `TAG_POWER:
                begin
                  if (byte_pos_reg == 8'h00)
                    power_class_reg <= I_BYTE;
                  else if (byte_pos_reg == 8'h01)
                    power_cons_reg <= I_BYTE;
                  else
                  begin
                    O_POWER_VALID <= 1'b1;
                    O_POWER_INDEX <= power_count_reg;
                    power_count_reg <= power_count_reg + 4'h1;
                    O_POWER_CLASS <= power_class_reg;
                    O_POWER_MA <= power_cons_reg[5:0];
                    O_POWER_MA_USABLE <= (power_cons_reg != `CONSUMPTION_NONE_LO)
                      && (power_cons_reg != `CONSUMPTION_NONE_HI)
                      && (power_cons_reg <= `CONSUMPTION_MAX);
                    O_POWER_FREQ <= I_BYTE;
                    O_POWER_FREQ_GIVEN <= (I_BYTE != `FREQ_NONE);
                  end
                end
                `TAG_MIN_CLOCK:
                begin
                  O_MINCLK_VALID <= 1'b1;
                  O_MINCLK_INDEX <= minclk_count_reg;
                  minclk_count_reg <= minclk_count_reg + 4'h1;
                  O_MINCLK_FREQ <= I_BYTE;
                  O_MINCLK_GIVEN <= (I_BYTE != `FREQ_NONE) && (I_BYTE >= `FREQ_MIN);
                end
                default:
                begin
                  // Memory count, most significant byte first
                  mem_acc_reg <= {mem_acc_reg[MEM_WIDTH-9:0], I_BYTE};
                  if (inner_left_reg == 8'h01)
                  begin
                    O_MEM_VALID <= 1'b1;
                    O_MEM_BYTES <= {mem_acc_reg[MEM_WIDTH-9:0], I_BYTE};
                  end
                end
              endcase
            end
            if (inner_left_reg == 8'h01)
            begin
              if (outer_left_reg == 8'h01)
              begin
                state_reg <= S_IDLE;
                O_DONE <= 1'b1;
                // Root file lacking characteristics is an error
                if (I_FILE_KIND == `FILE_ROOT && !seen_reg[0])
                  O_ERR_PERMISSION <= 1'b1;
              end
              else
                state_reg <= S_TAG;
            end
          end
          default:
          begin
            state_reg <= S_FAIL;
          end
        endcase
      end
    end
  end
endmodule // prop_tlv_decoder
`default_nettype wire

// >>> design/prop_tlv_regs.vh
// Constants for the proprietary information object decoder
`ifndef PROP_TLV_REGS_VH
`define PROP_TLV_REGS_VH
`define TAG_PROPRIETARY 8'hA5
`define TAG_CHARACTERISTICS 8'h80
`define TAG_POWER 8'h81
`define TAG_MIN_CLOCK 8'h82
`define TAG_MEMORY 8'h83
`define LEN_CHARACTERISTICS 8'h01
`define LEN_POWER 8'h03
`define LEN_MIN_CLOCK 8'h01
`define LEN_MEMORY_MIN 8'h02
`define CHR_STOP_ALLOWED 0
`define CHR_RESERVED_LO 1
`define CHR_HIGH_PREF 2
`define CHR_LOW_PREF 3
`define CHR_CLASS_A 4
`define CHR_CLASS_B 5
`define CHR_CLASS_C 6
`define CHR_RESERVED_HI 7
`define CONSUMPTION_MASK 8'h3F
`define CONSUMPTION_MAX 8'h3C
`define CONSUMPTION_NONE_LO 8'h00
`define CONSUMPTION_NONE_HI 8'hFF
`define FREQ_NONE 8'hFF
`define FREQ_MIN 8'h0A
`define FILE_ROOT 2'h0
`define FILE_APPLICATION 2'h1
`define FILE_DEDICATED 2'h2
`define FILE_ELEMENTARY 2'h3
`endif

// >>> design/tlv_field_check.v
// Inner object header check: known tag, length legality and permission by file kind
`timescale 1ns/10ps
`default_nettype none
`include "prop_tlv_regs.vh"
module tlv_field_check (
  input wire [7:0] i_tag,
  input wire [7:0] i_len,
  input wire [7:0] i_remaining,
  input wire [1:0] i_file_kind,
  output reg o_len_error,
  output reg o_not_permitted,
  output reg o_known
);
  always @*
  begin
    o_known = 1'b1;
    o_len_error = (i_len > i_remaining);
    o_not_permitted = 1'b0;
    case (i_tag)
      `TAG_CHARACTERISTICS:
      begin
        o_len_error = o_len_error | (i_len != `LEN_CHARACTERISTICS);
      end
      `TAG_POWER:
      begin
        o_len_error = o_len_error | (i_len != `LEN_POWER);
        o_not_permitted = (i_file_kind != `FILE_APPLICATION);
      end
      `TAG_MIN_CLOCK:
      begin
        o_len_error = o_len_error | (i_len != `LEN_MIN_CLOCK);
        o_not_permitted = (i_file_kind != `FILE_APPLICATION);
      end
      `TAG_MEMORY:
      begin
        o_len_error = o_len_error | (i_len < `LEN_MEMORY_MIN);
        o_not_permitted = (i_file_kind == `FILE_ELEMENTARY);
      end
      default:
      begin
        o_known = 1'b0;
      end
    endcase
  end
endmodule // tlv_field_check
`default_nettype wire

// >>> bench/card_object_source.sv
// Card-side model that streams a proprietary object byte by byte
`timescale 1ns/10ps
`default_nettype none
module card_object_source (
  input wire logic i_clock,
  output logic o_valid,
  output logic [7:0] o_data
);
  initial
  begin
    o_valid = 1'b0;
    o_data = 8'h00;
  end
  // Tag, length and value bytes go out in list order, back to back
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      @(posedge i_clock);
      o_valid <= 1'b1;
      o_data <= b[i];
    end
    @(posedge i_clock);
    o_valid <= 1'b0;
    // Released data line shows no stale byte
    o_data <= ~o_data;
  endtask
endmodule // card_object_source
`default_nettype wire

// >>> bench/prop_tlv_checker_assertions.sv
// Port-level checks for the proprietary object decoder
`timescale 1ns/10ps
`default_nettype none
module prop_tlv_checker (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic I_START,
  input wire logic O_BUSY,
  input wire logic O_DONE,
  input wire logic O_ERROR,
  input wire logic O_CHR_VALID,
  input wire logic O_STOP_HIGH,
  input wire logic O_STOP_LOW,
  input wire logic O_STOP_LEVEL_RFU,
  input wire logic O_POWER_VALID,
  input wire logic [5:0] O_POWER_MA,
  input wire logic O_POWER_MA_USABLE,
  input wire logic [7:0] O_POWER_FREQ,
  input wire logic O_POWER_FREQ_GIVEN,
  input wire logic O_MINCLK_VALID,
  input wire logic [3:0] O_MINCLK_INDEX,
  input wire logic [7:0] O_MINCLK_FREQ,
  input wire logic O_MINCLK_GIVEN,
  input wire logic O_MEM_VALID
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  done_pulse_a: assert property (O_DONE |=> !O_DONE)
    else $error("done longer than one cycle");
  idle_quiet_a: assert property (!O_BUSY && !I_START |=>
    !O_DONE && !O_POWER_VALID && !O_MINCLK_VALID && !O_MEM_VALID)
    else $error("result while idle");
  start_clears_a: assert property (I_START |=> !O_ERROR)
    else $error("error flag kept over restart");
  power_pulse_a: assert property (O_POWER_VALID |=> !O_POWER_VALID)
    else $error("power result longer than one cycle");
  power_usable_a: assert property (O_POWER_VALID && O_POWER_MA_USABLE |->
    O_POWER_MA != 6'h00 && O_POWER_MA <= 6'h3C)
    else $error("unusable consumption flagged usable");
  freq_given_a: assert property (O_POWER_VALID |->
    O_POWER_FREQ_GIVEN == (O_POWER_FREQ != 8'hFF))
    else $error("reference frequency flag wrong");
  minclk_given_a: assert property (O_MINCLK_VALID |->
    O_MINCLK_GIVEN == (O_MINCLK_FREQ >= 8'h0A && O_MINCLK_FREQ != 8'hFF))
    else $error("minimum clock flag wrong");
  minclk_order_a: assert property ((O_MINCLK_VALID ##3 O_MINCLK_VALID) |->
    O_MINCLK_INDEX == $past(O_MINCLK_INDEX, 3) + 4'h1)
    else $error("minimum clock ordinal not stepped");
  stop_rfu_a: assert property (O_CHR_VALID |->
    O_STOP_LEVEL_RFU == (O_STOP_HIGH && O_STOP_LOW))
    else $error("stop level reserved flag wrong");
endmodule // prop_tlv_checker
bind prop_tlv_decoder prop_tlv_checker prop_tlv_checker_i (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN),
  .I_START(I_START), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_ERROR(O_ERROR),
  .O_CHR_VALID(O_CHR_VALID), .O_STOP_HIGH(O_STOP_HIGH), .O_STOP_LOW(O_STOP_LOW),
  .O_STOP_LEVEL_RFU(O_STOP_LEVEL_RFU), .O_POWER_VALID(O_POWER_VALID), .O_POWER_MA(O_POWER_MA),
  .O_POWER_MA_USABLE(O_POWER_MA_USABLE), .O_POWER_FREQ(O_POWER_FREQ),
  .O_POWER_FREQ_GIVEN(O_POWER_FREQ_GIVEN), .O_MINCLK_VALID(O_MINCLK_VALID),
  .O_MINCLK_INDEX(O_MINCLK_INDEX), .O_MINCLK_FREQ(O_MINCLK_FREQ),
  .O_MINCLK_GIVEN(O_MINCLK_GIVEN), .O_MEM_VALID(O_MEM_VALID));
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the proprietary object decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock, rstn, start, bvalid;
  logic [1:0] kind;
  logic [7:0] bdata;
  wire logic busy, done, err, err_ord, err_perm, err_res, chr_v, stop_al, stop_hi, stop_lo;
  wire logic stop_rfu, cls_a, cls_b, cls_c, pw_v, pw_use, pw_fg, mc_v, mc_g, mem_v;
  wire logic [3:0] pw_idx, mc_idx;
  wire logic [7:0] pw_cls, pw_fr, mc_fr;
  wire logic [5:0] pw_ma;
  wire logic [31:0] mem_b;
  int err_count = 0, total_checks = 0, done_cnt = 0;
  logic [12:0] mc_q[$];
  logic [27:0] pw_q[$];
  logic [31:0] mem_seen;
  prop_tlv_decoder #(.MEM_WIDTH(32)) prop_tlv_decoder_i (.I_CLOCK(clock), .I_RSTN(rstn),
    .I_START(start), .I_FILE_KIND(kind), .I_BYTE_VALID(bvalid), .I_BYTE(bdata), .O_BUSY(busy),
    .O_DONE(done), .O_ERROR(err), .O_ERR_ORDER(err_ord), .O_ERR_PERMISSION(err_perm),
    .O_ERR_RESERVED(err_res), .O_CHR_VALID(chr_v), .O_STOP_ALLOWED(stop_al),
    .O_STOP_HIGH(stop_hi), .O_STOP_LOW(stop_lo), .O_STOP_LEVEL_RFU(stop_rfu), .O_CLASS_A(cls_a),
    .O_CLASS_B(cls_b), .O_CLASS_C(cls_c), .O_POWER_VALID(pw_v), .O_POWER_INDEX(pw_idx),
    .O_POWER_CLASS(pw_cls), .O_POWER_MA(pw_ma), .O_POWER_MA_USABLE(pw_use), .O_POWER_FREQ(pw_fr),
    .O_POWER_FREQ_GIVEN(pw_fg), .O_MINCLK_VALID(mc_v), .O_MINCLK_INDEX(mc_idx),
    .O_MINCLK_FREQ(mc_fr), .O_MINCLK_GIVEN(mc_g), .O_MEM_VALID(mem_v), .O_MEM_BYTES(mem_b));
  card_object_source card_object_source_i (.i_clock(clock), .o_valid(bvalid), .o_data(bdata));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Collects the one-cycle result pulses
  always @(posedge clock)
  begin
    if (done === 1'b1) done_cnt++;
    if (mc_v === 1'b1) mc_q.push_back({mc_idx, mc_fr, mc_g});
    if (pw_v === 1'b1) pw_q.push_back({pw_idx, pw_cls, pw_ma, pw_use, pw_fr, pw_fg});
    if (mem_v === 1'b1) mem_seen = mem_b;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic chk_chr(input logic [7:0] v);
    chk("characteristics", {1'b1, v[0], v[2], v[3], v[2] & v[3], v[4], v[5], v[6]},
      {chr_v, stop_al, stop_hi, stop_lo, stop_rfu, cls_a, cls_b, cls_c});
  endtask
  task automatic run(input logic [1:0] k, input logic [7:0] b[$]);
    mc_q.delete();
    pw_q.delete();
    mem_seen = 32'h0;
    @(posedge clock);
    start <= 1'b1;
    kind <= k;
    @(posedge clock);
    start <= 1'b0;
    card_object_source_i.send(b);
    // Results follow the last byte by one cycle
    repeat (2) @(posedge clock);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    int d0;
    logic [7:0] cv[8];
    cv = '{8'h00, 8'h01, 8'h05, 8'h09, 8'h0D, 8'h04, 8'h08, 8'h70};
    rstn = 1'b0;
    start = 1'b0;
    kind = 2'h0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    d0 = done_cnt;
    run(2'h1, {8'hA5, 8'h03, 8'h82, 8'h01, 8'h0A});
    chk("done", d0 + 1, done_cnt);
    chk("minclk count", 32'h1, mc_q.size());
    chk("minclk", {4'h0, 8'h0A, 1'b1}, mc_q[0]);
    chk("busy", 32'h0, busy);
    d0 = done_cnt;
    run(2'h1, {8'hA5, 8'h00});
    chk("empty done", d0 + 1, done_cnt);
    run(2'h0, {8'hA5, 8'h00});
    chk("root empty", 32'h1, err_perm);
    run(2'h1, {8'hA5, 8'h13, 8'h80, 8'h01, 8'h75, 8'h81, 8'h03, 8'h01, 8'h3C, 8'hFF,
      8'h82, 8'h01, 8'hFF, 8'h82, 8'h01, 8'h14, 8'h83, 8'h03, 8'h01, 8'h23, 8'h45});
    chk_chr(8'h75);
    chk("power count", 32'h1, pw_q.size());
    chk("power", {4'h0, 8'h01, 6'h3C, 1'b1, 8'hFF, 1'b0}, pw_q[0]);
    chk("minclk count", 32'h2, mc_q.size());
    chk("minclk first", {4'h0, 8'hFF, 1'b0}, mc_q[0]);
    chk("minclk second", {4'h1, 8'h14, 1'b1}, mc_q[1]);
    chk("memory", 32'h00012345, mem_seen);
    chk("flags", 4'h0, {err, err_ord, err_perm, err_res});
    for (int k = 0; k < 4; k++)
    begin
      run(k[1:0], {8'hA5, 8'h04, 8'h83, 8'h02, 8'h00, 8'h10});
      chk("permission", (k == 0 || k == 3), err_perm);
      chk("memory", 32'h10, mem_seen);
    end
    run(2'h0, {8'hA5, 8'h08, 8'h80, 8'h01, 8'h01, 8'h81, 8'h03, 8'h04, 8'hFF, 8'h0A});
    chk("root power", 32'h1, err_perm);
    chk("power", {4'h0, 8'h04, 6'h3F, 1'b0, 8'h0A, 1'b1}, pw_q[0]);
    chk("power class", 32'h04, pw_q[0][23:16]);
    run(2'h1, {8'hA5, 8'h0A, 8'h82, 8'h01, 8'h0A, 8'h83, 8'h02, 8'h00, 8'h01, 8'h82, 8'h01,
      8'h0B});
    chk("order", 32'h1, err_ord);
    run(2'h0, {8'hA5, 8'h03, 8'h80, 8'h01, 8'h82});
    chk("reserved", 32'h1, err_res);
    chk_chr(8'h82);
    run(2'h0, {8'h80, 8'h01, 8'h00});
    chk("outer tag", 32'h1, err);
    chk("busy fail", 32'h1, busy);
    // Reset in mid-run leaves the failed state and clears the flags
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk("reset", 32'h0, {busy, err});
    run(2'h1, {8'hA5, 8'h03, 8'h83, 8'h05, 8'h00});
    chk("overrun", 32'h1, err);
    run(2'h1, {8'hA5, 8'h04, 8'h80, 8'h02, 8'h00, 8'h00});
    chk("fixed length", 32'h1, err);
    run(2'h1, {8'hA5, 8'h04, 8'h83, 8'h03, 8'h00, 8'h01});
    chk("overrun edge", 32'h1, err);
    run(2'h1, {8'hA5, 8'h01, 8'h83});
    chk("tag only", 32'h1, err);
    foreach (cv[i])
    begin
      run(2'h0, {8'hA5, 8'h03, 8'h80, 8'h01, cv[i]});
      chk_chr(cv[i]);
      chk("flags", 4'h0, {err, err_ord, err_perm, err_res});
    end
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
